//--- design/radio_sleep_wake_sequencer.sv
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
`include "sleep_seq_regs.svh"
// How it works
// - Sleep is entered only when the role bit says end device.
// - A sleep request counts only in run mode, never in programming mode.
// - Each sleep period ends in a parent poll; a message restarts the host.
// - With the options flag set, count expiry restarts the host without a message.
// - Stay-awake counts milliseconds; any received data reloads it.
// - Sleep period counts 10 ms ticks, then a brief poll of the parent.
// - Written sleep period is rounded to the nearest quarter second.
// - Poll time adds to each period, so total sleep exceeds count times period.
// - The period count sets how many empty periods pass before host wake.
// - After a wake with message, the message is held for wake-hold time.
// - Options flag picks host wake or reload-and-resume on count expiry.
// - Host wake is a full restart: reset held through sleep, released at wake.
// - After a request, stay awake for stay-awake time; received data restarts it.
module radio_sleep_wake_sequencer #(
  parameter int MS_CYCLES = `CLK_MHZ * `TIME_MS_US
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Radio side
  input  wire logic        data_rx,
  input  wire logic        poll_ack,
  input  wire logic        poll_msg,
  output logic             poll_req,
  // Host side
  output logic             host_power_en,
  output logic             host_rst,
  output logic             msg_hold,
  output logic             sleeping
);
  // ***************************************************************
  // State
  // ***************************************************************
  sleep_seq_pkg::seq_regs_t s;
  sleep_seq_pkg::seq_regs_t next_s;
  logic ms_tick;
  logic ten_tick;
  logic wr_en;

  localparam logic [31:0] MS_LAST = 32'(MS_CYCLES - 1);

  // Rounds to the nearest multiple of the quarter-second grain.
  function automatic logic [15:0] round_sp(input logic [15:0] v);
    logic [16:0] sum;
    sum = {1'b0, v} + {1'b0, `SP_HALF_GRAIN};
    return 16'((sum / 17'(`SP_GRAIN)) * 17'(`SP_GRAIN));
  endfunction

  assign ms_tick  = (s.ms_div == MS_LAST);
  assign ten_tick = ms_tick && (s.ten_div == `TICKS_PER_10MS - 4'h1);
  assign wr_en    = psel && penable && s.pready && pwrite;

  always_comb begin
    next_s = s;
    next_s.ctrl[`CTRL_SLEEP_REQ] = 1'b0;
    // ***************************************************************
    // APB slave: one wait-free access phase
    // ***************************************************************
    // Reads are decoded in the setup cycle, so the answer stands in the first
    // access cycle and no transfer ever needs a wait state.
    next_s.pready = psel && !penable;
    next_s.pslverr = 1'b0;
    if (psel && !penable) begin
      next_s.prdata = 32'h0;
      if (paddr == `ADDR_CTRL) begin
        next_s.prdata = {28'h0, s.ctrl};
      end else if (paddr == `ADDR_STAY) begin
        next_s.prdata = {16'h0, s.stay_awake_time};
      end else if (paddr == `ADDR_SP) begin
        next_s.prdata = {16'h0, s.sleep_period};
      end else if (paddr == `ADDR_SN) begin
        next_s.prdata = {16'h0, s.sleep_period_count};
      end else if (paddr == `ADDR_WH) begin
        next_s.prdata = {16'h0, s.wake_hold_time};
      end else if (paddr == `ADDR_STATUS) begin
        next_s.prdata = {s.periods, 12'h0, s.msg_hold, 3'(s.state)};
      end else begin
        next_s.pslverr = 1'b1;
      end
    end
    if (wr_en) begin
      if (paddr == `ADDR_CTRL) begin
        next_s.ctrl = pwdata[3:0];
      end else if (paddr == `ADDR_STAY) begin
        next_s.stay_awake_time = pwdata[15:0];
      end else if (paddr == `ADDR_SP) begin
        next_s.sleep_period = round_sp(pwdata[15:0]);
      end else if (paddr == `ADDR_SN) begin
        next_s.sleep_period_count = pwdata[15:0];
      end else if (paddr == `ADDR_WH) begin
        next_s.wake_hold_time = pwdata[15:0];
      end
    end
    // ***************************************************************
    // Tick bases
    // ***************************************************************
    // Both dividers run free except where the sequencer restarts them.
    // A restart costs up to one tick of skew but makes every sleep period
    // a whole number of ticks measured from its own start.
    next_s.ms_div = ms_tick ? 32'h0 : s.ms_div + 32'h1;
    if (ms_tick) begin
      next_s.ten_div = ten_tick ? 4'h0 : s.ten_div + 4'h1;
    end
    // ***************************************************************
    // Sequencer
    // ***************************************************************
    next_s.poll_req = 1'b0;
    case (s.state)
      sleep_seq_pkg::AWAKE: begin
        next_s.host_power_en = 1'b1;
        next_s.host_rst = 1'b0;
        // The request bit clears itself one cycle after the write, so a request
        // made outside the end device role or outside run mode is simply lost.
        if (s.ctrl[`CTRL_SLEEP_REQ] && s.ctrl[`CTRL_END_DEV] && s.ctrl[`CTRL_RUN_MODE]) begin
          next_s.state = sleep_seq_pkg::STAY;
          next_s.timer = s.stay_awake_time;
        end
      end
      sleep_seq_pkg::STAY: begin
        if (data_rx) begin
          next_s.timer = s.stay_awake_time;
        end else if (ms_tick) begin
          if (s.timer <= 16'h1) begin
            // Cutting power also holds the host in reset, so any wake is a cold start.
            next_s.state = sleep_seq_pkg::SLEEP;
            next_s.host_power_en = 1'b0;
            next_s.host_rst = 1'b1;
            next_s.timer = s.sleep_period;
            next_s.periods = 16'h0;
            next_s.ms_div = 32'h0;
            next_s.ten_div = 4'h0;
          end else begin
            next_s.timer = s.timer - 16'h1;
          end
        end
      end
      sleep_seq_pkg::SLEEP: begin
        if (ten_tick) begin
          if (s.timer <= 16'h1) begin
            next_s.state = sleep_seq_pkg::POLL;
            next_s.poll_req = 1'b1;
          end else begin
            next_s.timer = s.timer - 16'h1;
          end
        end
      end
      sleep_seq_pkg::POLL: begin
        // The period timer restarts only after the answer, so poll time adds on.
        next_s.poll_req = !poll_ack;
        if (poll_ack) begin
          next_s.timer = s.sleep_period;
          // The next period is timed from the answer, not from the free-running grid.
          next_s.ms_div = 32'h0;
          next_s.ten_div = 4'h0;
          if (poll_msg) begin
            next_s.state = sleep_seq_pkg::HOLD;
            next_s.periods = 16'h0;
            next_s.host_power_en = 1'b1;
            next_s.host_rst = 1'b0;
            next_s.msg_hold = 1'b1;
            next_s.timer = s.wake_hold_time;
          end else if (s.periods + 16'h1 >= s.sleep_period_count) begin
            next_s.periods = 16'h0;
            if (s.ctrl[`CTRL_WAKE_EXP]) begin
              next_s.state = sleep_seq_pkg::AWAKE;
              next_s.host_power_en = 1'b1;
              next_s.host_rst = 1'b0;
            end else begin
              next_s.state = sleep_seq_pkg::SLEEP;
            end
          end else begin
            next_s.state = sleep_seq_pkg::SLEEP;
            next_s.periods = s.periods + 16'h1;
          end
        end
      end
      sleep_seq_pkg::HOLD: begin
        // The host already runs here; the message is only offered for a while.
        if (ms_tick) begin
          if (s.timer <= 16'h1) begin
            next_s.state = sleep_seq_pkg::AWAKE;
            next_s.msg_hold = 1'b0;
          end else begin
            next_s.timer = s.timer - 16'h1;
          end
        end
      end
      default: begin
        next_s.state = sleep_seq_pkg::AWAKE;
      end
    endcase
    // Kept as its own flop so that the output needs no inverter after the register.
    next_s.sleeping = !next_s.host_power_en;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s <= '{state: sleep_seq_pkg::AWAKE, ctrl: `RST_CTRL, stay_awake_time: `RST_STAY,
             sleep_period: `RST_SP, sleep_period_count: `RST_SN, wake_hold_time: `RST_WH,
             host_power_en: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign prdata        = s.prdata;
  assign pready        = s.pready;
  assign pslverr       = s.pslverr;
  assign poll_req      = s.poll_req;
  assign host_power_en = s.host_power_en;
  assign host_rst      = s.host_rst;
  assign msg_hold      = s.msg_hold;
  assign sleeping      = s.sleeping;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  // All checks share the system clock and stay quiet during reset.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  property p_role_gate;
    $past(s.state) == sleep_seq_pkg::AWAKE && s.state == sleep_seq_pkg::STAY
      |-> $past(s.ctrl[`CTRL_END_DEV]);
  endproperty
  a_role_gate: assert property (p_role_gate) else $error("sleep entered outside end device role");

  property p_run_gate;
    $past(s.state) == sleep_seq_pkg::AWAKE && s.state == sleep_seq_pkg::STAY
      |-> $past(s.ctrl[`CTRL_RUN_MODE]);
  endproperty
  a_run_gate: assert property (p_run_gate) else $error("sleep entered in programming mode");

  property p_msg_wakes;
    s.state == sleep_seq_pkg::POLL && poll_ack && poll_msg
      |=> s.state == sleep_seq_pkg::HOLD && host_power_en && !host_rst && msg_hold;
  endproperty
  a_msg_wakes: assert property (p_msg_wakes) else $error("message poll did not restart host");

  property p_expiry_wake;
    s.state == sleep_seq_pkg::POLL && poll_ack && !poll_msg && s.ctrl[`CTRL_WAKE_EXP]
      && s.periods + 16'h1 >= s.sleep_period_count |=> s.state == sleep_seq_pkg::AWAKE && host_power_en;
  endproperty
  a_expiry_wake: assert property (p_expiry_wake) else $error("count expiry did not wake host");

  property p_expiry_resume;
    s.state == sleep_seq_pkg::POLL && poll_ack && !poll_msg && !s.ctrl[`CTRL_WAKE_EXP]
      |=> s.state == sleep_seq_pkg::SLEEP && !host_power_en;
  endproperty
  a_expiry_resume: assert property (p_expiry_resume) else $error("empty poll did not resume sleep");

  property p_data_reload;
    s.state == sleep_seq_pkg::STAY && data_rx |=> s.timer == $past(s.stay_awake_time);
  endproperty
  a_data_reload: assert property (p_data_reload) else $error("received data did not reload timer");

  property p_sp_round;
    wr_en && paddr == `ADDR_SP |=> s.sleep_period % `SP_GRAIN == 16'h0;
  endproperty
  a_sp_round: assert property (p_sp_round) else $error("sleep period not rounded");

  property p_power_reset;
    !host_power_en |-> host_rst;
  endproperty
  a_power_reset: assert property (p_power_reset) else $error("host unpowered without reset");

  property p_msg_clears;
    s.state == sleep_seq_pkg::POLL && poll_ack && poll_msg |=> s.periods == 16'h0;
  endproperty
  a_msg_clears: assert property (p_msg_clears) else $error("period count not cleared");

  property p_poll_order;
    s.state == sleep_seq_pkg::SLEEP && ten_tick && s.timer <= 16'h1 |=> poll_req ##0 s.state == sleep_seq_pkg::POLL;
  endproperty
  a_poll_order: assert property (p_poll_order) else $error("period end did not poll");

  property p_stay_entry;
    $past(s.state) == sleep_seq_pkg::AWAKE && s.state == sleep_seq_pkg::STAY
      |-> s.timer == $past(s.stay_awake_time);
  endproperty
  a_stay_entry: assert property (p_stay_entry) else $error("stay timer not loaded at request");

  property p_stay_power;
    s.state == sleep_seq_pkg::STAY |-> host_power_en && !host_rst;
  endproperty
  a_stay_power: assert property (p_stay_power) else $error("host lost power during stay time");

  property p_hold_state;
    s.state == sleep_seq_pkg::HOLD |-> msg_hold && host_power_en && !host_rst;
  endproperty
  a_hold_state: assert property (p_hold_state) else $error("message not held for running host");

  property p_hold_exit;
    s.state == sleep_seq_pkg::HOLD && ms_tick && s.timer <= 16'h1
      |=> s.state == sleep_seq_pkg::AWAKE && !msg_hold;
  endproperty
  a_hold_exit: assert property (p_hold_exit) else $error("message hold did not end");

  property p_count_step;
    s.state == sleep_seq_pkg::POLL && poll_ack && !poll_msg && s.periods + 16'h1 < s.sleep_period_count
      |=> s.state == sleep_seq_pkg::SLEEP && s.periods == $past(s.periods) + 16'h1;
  endproperty
  a_count_step: assert property (p_count_step) else $error("empty poll not counted");

  property p_poll_adds;
    s.state == sleep_seq_pkg::POLL && poll_ack |=> s.ms_div == 32'h0 && s.ten_div == 4'h0;
  endproperty
  a_poll_adds: assert property (p_poll_adds) else $error("period not timed from poll answer");

  property p_sleep_reset;
    s.state == sleep_seq_pkg::SLEEP || s.state == sleep_seq_pkg::POLL
      |-> !host_power_en && host_rst && sleeping;
  endproperty
  a_sleep_reset: assert property (p_sleep_reset) else $error("host not held off while asleep");

  property p_poll_hold;
    s.state == sleep_seq_pkg::POLL && !poll_ack
      |=> s.state == sleep_seq_pkg::POLL && poll_req;
  endproperty
  a_poll_hold: assert property (p_poll_hold) else $error("poll dropped before answer");

  c_sleep: cover property (s.state == sleep_seq_pkg::STAY ##1 s.state == sleep_seq_pkg::SLEEP);
  c_msg_wake: cover property (s.state == sleep_seq_pkg::HOLD);
  c_exp_wake: cover property (s.state == sleep_seq_pkg::POLL ##1 s.state == sleep_seq_pkg::AWAKE);
  c_bad_addr: cover property (pslverr);
  c_resume: cover property (s.state == sleep_seq_pkg::POLL && poll_ack && !poll_msg && !s.ctrl[`CTRL_WAKE_EXP]);
endmodule

//--- inc/sleep_seq_pkg.sv
package sleep_seq_pkg;
  typedef enum logic [2:0] {AWAKE, STAY, SLEEP, POLL, HOLD} seq_state_t;

  typedef struct packed {
    seq_state_t  state;
    logic [3:0]  ctrl;
    logic [15:0] stay_awake_time;
    logic [15:0] sleep_period;
    logic [15:0] sleep_period_count;
    logic [15:0] wake_hold_time;
    logic [31:0] ms_div;
    logic [3:0]  ten_div;
    logic [15:0] timer;
    logic [15:0] periods;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        host_power_en;
    logic        sleeping;
    logic        host_rst;
    logic        poll_req;
    logic        msg_hold;
  } seq_regs_t;
endpackage

//--- inc/sleep_seq_regs.svh
`ifndef SLEEP_SEQ_REGS_SVH
`define SLEEP_SEQ_REGS_SVH
// ***************************************************************
// Register offsets, fields and reset values
// ***************************************************************
`define ADDR_CTRL       8'h00
`define ADDR_STAY       8'h04
`define ADDR_SP         8'h08
`define ADDR_SN         8'h0c
`define ADDR_WH         8'h10
`define ADDR_STATUS     8'h14
`define CTRL_END_DEV    0
`define CTRL_RUN_MODE   1
`define CTRL_WAKE_EXP   2
`define CTRL_SLEEP_REQ  3
`define RST_CTRL        4'h0
`define RST_STAY        16'h07d0
`define RST_SP          16'h0064
`define RST_SN          16'h0001
`define RST_WH          16'h0bb8
// ***************************************************************
// Timing
// ***************************************************************
`define CLK_MHZ         200
`define TIME_MS_US      1000
`define TICKS_PER_10MS  4'ha
`define SP_GRAIN        16'h0019
`define SP_HALF_GRAIN   16'h000c
`endif

//--- tb/parent_node_model.sv
`timescale 1ns/100ps
// ***************************************************************
// Parent node: answers each poll after 0 to 3 idle cycles
// ***************************************************************
module parent_node_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // Poll handshake
  input  wire logic       poll_req,
  output logic            poll_ack,
  output logic            poll_msg,
  // Bench control
  input  wire logic       give_msg,
  input  wire logic [1:0] delay
);
  logic [2:0] wait_cnt;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      poll_ack <= 1'b0;
      poll_msg <= 1'b0;
      wait_cnt <= 3'h0;
    end else if (poll_req && !poll_ack && wait_cnt >= {1'b0, delay}) begin
      poll_ack <= 1'b1;
      poll_msg <= give_msg;
      wait_cnt <= 3'h0;
    end else begin
      // The message line is only meaningful with the answer, so it toggles otherwise.
      poll_ack <= 1'b0;
      poll_msg <= ~poll_msg;
      wait_cnt <= poll_req ? wait_cnt + 3'h1 : 3'h0;
    end
  end
endmodule

//--- tb/tb.sv
`timescale 1ns/100ps
`include "sleep_seq_regs.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb;
  logic        sys_clk  = 1'b0;
  logic        srst     = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic        data_rx  = 1'b0;
  logic        give_msg = 1'b0;
  logic [1:0]  delay    = 2'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, poll_ack, poll_msg, poll_req;
  logic        host_power_en, host_rst, msg_hold, sleeping;
  logic [31:0] seed = 32'h00014bf8;
  logic [31:0] q;
  logic        e;
  int          model[5];
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          polls = 0;
  int          n, i;

  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (poll_ack === 1'b1) polls++;

  // Two cycles per millisecond keep the 2000 ms stay-awake inside the run.
  radio_sleep_wake_sequencer #(.MS_CYCLES(2)) radio_sleep_wake_sequencer_i (
    .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .data_rx(data_rx), .poll_ack(poll_ack), .poll_msg(poll_msg), .poll_req(poll_req),
    .host_power_en(host_power_en), .host_rst(host_rst), .msg_hold(msg_hold), .sleeping(sleeping));
  parent_node_model parent_node_model_i (
    .sys_clk(sys_clk), .srst(srst), .poll_req(poll_req), .poll_ack(poll_ack),
    .poll_msg(poll_msg), .give_msg(give_msg), .delay(delay));

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function logic cond(int w);
    case (w)
      0: return host_power_en === 1'b0;
      1: return host_power_en === 1'b1;
      2: return msg_hold === 1'b0;
      3: return poll_req === 1'b1;
      default: return polls >= w - 4;
    endcase
  endfunction

  task end_of_test();
    if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task wait_until(input int w, input int bound);
    n = 0;
    while (!cond(w)) begin
      @(posedge sys_clk);
      n++;
      if (n > bound) begin
        n_mismatch++;
        end_of_test();
      end
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
      if (k > 20) begin
        n_mismatch++;
        end_of_test();
      end
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Sleep period reads back rounded to the nearest 25 hundredths.
  task wr(input int r, input int d);
    apb(1'b1, 8'(r * 4), d);
    model[r] = (r == 0) ? (d & 7) : (r == 2) ? ((d + 12) / 25) * 25 : (d & 16'hffff);
  endtask

  task chk_reg(input int r);
    apb(1'b0, 8'(r * 4), 32'h0);
    `CHK("register", 32'(model[r]), q)
  endtask

  initial begin
    model = '{`RST_CTRL, `RST_STAY, `RST_SP, `RST_SN, `RST_WH};
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    for (i = 0; i < 5; i++) chk_reg(i);
    apb(1'b0, 8'h18, 32'h0);
    `CHK("unmapped_err", 1'b1, e)
    for (i = 0; i < 8; i++) begin
      wr(2, rnd() % 2801);
      chk_reg(2);
    end
    wr(2, 30);
    wr(4, 100);
    wr(1, 2000);
    wr(3, 5);
    wr(0, 32'h9);
    chk_reg(0);
    apb(1'b0, 8'h14, 32'h0);
    `CHK("state_program_mode", 3'h0, q[2:0])
    wr(0, 32'ha);
    apb(1'b0, 8'h14, 32'h0);
    `CHK("state_router", 3'h0, q[2:0])
    delay <= 2'(rnd() % 4);
    wr(0, 32'hb);
    apb(1'b0, 8'h14, 32'h0);
    `CHK("state_stay", 3'h1, q[2:0])
    repeat (1000) @(posedge sys_clk);
    data_rx <= 1'b1;
    @(posedge sys_clk);
    data_rx <= 1'b0;
    wait_until(0, 6000);
    `CHK("stay_cycles", 1'b1, n >= 3990 && n <= 4010)
    `CHK("host_rst_sleep", 1'b1, host_rst)
    `CHK("sleeping_on", 1'b1, sleeping)
    polls = 0;
    wait_until(3, 700);
    `CHK("period_cycles", 1'b1, n >= 480 && n <= 520)
    wait_until(4 + 1, 50);
    repeat (2) @(posedge sys_clk);
    apb(1'b0, 8'h14, 32'h0);
    `CHK("elapsed_one", 16'h1, q[31:16])
    give_msg <= 1'b1;
    wait_until(1, 1200);
    `CHK("msg_hold_on", 1'b1, msg_hold)
    `CHK("host_rst_wake", 1'b0, host_rst)
    `CHK("sleeping_off", 1'b0, sleeping)
    apb(1'b0, 8'h14, 32'h0);
    `CHK("elapsed_clear", 16'h0, q[31:16])
    wait_until(2, 400);
    `CHK("hold_cycles", 1'b1, n >= 180 && n <= 210)
    give_msg <= 1'b0;
    delay <= 2'(rnd() % 4);
    wr(3, 3);
    wr(0, 32'hf);
    wait_until(0, 4100);
    polls = 0;
    wait_until(1, 4000);
    `CHK("timeout_polls", 3, polls)
    `CHK("timeout_overhead", 1'b1, n > 1500)
    `CHK("timeout_no_hold", 1'b0, msg_hold)
    wr(3, 2);
    wr(0, 32'hb);
    wait_until(0, 4100);
    polls = 0;
    wait_until(4 + 5, 4000);
    `CHK("resume_sleep", 1'b0, host_power_en)
    apb(1'b0, 8'h14, 32'h0);
    `CHK("resume_elapsed", 16'h1, q[31:16])
    `CHK("resume_state", 3'h2, q[2:0])
    give_msg <= 1'b1;
    wait_until(1, 1200);
    `CHK("resume_msg_wake", 1'b1, msg_hold)
    end_of_test();
  end
endmodule
